// >>> bper_pkg.sv
// package for the bridge parity and system error report block
package bper_pkg;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFF_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_DISABLE    = 8'h04;
  localparam logic [7:0] OFF_REASON     = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;
  localparam logic [7:0] OFF_RETRY_MAX  = 8'h18;

  // control register field positions
  localparam int CTL_PRI_PERR_RESP = 0;
  localparam int CTL_SERR_EN       = 1;
  localparam int CTL_SEC_PERR_RESP = 2;
  localparam int CTL_SERR_FWD_EN   = 3;
  localparam int CTL_MTO_SERR_EN   = 4;
  localparam logic [4:0] CTL_RESET = 5'h00;

  // event bit positions shared by reason, disable, irq status and mask
  localparam int EV_PARITY   = 0;
  localparam int EV_TABORT   = 1;
  localparam int EV_MABORT   = 2;
  localparam int EV_PW_RETRY = 3;
  localparam int EV_DW_RETRY = 4;
  localparam int EV_DR_RETRY = 5;
  localparam int EV_MTO      = 6;
  localparam int EV_SEC_SERR = 7;
  localparam int NUM_EV      = 8;
  localparam logic [7:0] EV_RESET = 8'h00;

  // status register field positions
  localparam int ST_SIGNALED_SERR = 0;
  localparam int ST_RECEIVED_SERR = 1;

  // default retry limit: two to the 24th target retries
  localparam logic [24:0] RETRY_MAX_RESET = 25'h1000000;

  // transaction kind seen with a parity error report
  typedef enum logic [1:0] {BPER_READ, BPER_POSTED, BPER_DELAYED} bper_kind_t;

  // one parity observation on a bus
  typedef struct packed {
    logic       active;     // bridge takes part in a data phase
    bper_kind_t kind;
    logic       upstream;   // 1: secondary to primary
    logic       is_target;  // bridge is target on this bus
    logic       own_detect; // parity error detected by the bridge itself
  } bper_phase_t;

  // forwarding-engine event pulses
  typedef struct packed {
    logic tabort_pw;
    logic mabort_pw;
    logic retry_pw;
    logic retry_dw;
    logic retry_dr;
    logic mto_dt;
  } bper_fwd_ev_t;

  // whole block state
  typedef struct packed {
    logic [4:0]  ctl;
    logic [7:0]  disable_m;
    logic [7:0]  reason;
    logic [1:0]  status;
    logic [7:0]  irq_st;
    logic [7:0]  irq_mask;
    logic [24:0] retry_max;
    logic        pserr;
    logic        sperr;
    logic [2:0]  ssync;
    logic [2:0]  psync;
    logic [31:0] prdata;
  } bper_state_t;

endpackage : bper_pkg

// >>> bper_top.sv
// parity error and system error reporting logic of the bridge
// How it works
// R1 - secondary parity output on secondary target-write/initiator-read
// R2 - secondary parity output for upstream delayed write
// R3 - parity system error only far-side posted writes
// R4 - no system error for self-detected target parity
// R5 - parity system error needs both response bits
// R6 - system error enable gates every cause
// R7 - asserting system error sets signaled status
// R8 - forward secondary system error when enabled
// R9 - secondary system error sets received status
// R10 - posted write target abort raises error
// R11 - posted write master abort raises error
// R12 - posted write retry exhaustion raises error
// R13 - delayed write retry exhaustion raises error
// R14 - delayed read retry exhaustion raises error
// R15 - delayed transaction master timeout raises error
// R16 - reason register records each cause
// R17 - disable bits suppress per-event system error
// R18 - master timeout gated only by control bit
// R19 - no error for read/delayed-write parity
//
// The register addresses and the APB slave port were decided locally.
module bper_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire bper_pkg::bper_phase_t pri_phase,
  input  wire bper_pkg::bper_phase_t sec_phase,
  input  wire bper_pkg::bper_fwd_ev_t fwd_ev,
  input  wire logic [24:0]           retry_count,
  input  wire logic                  primary_parity_error_n,
  input  wire logic                  secondary_system_error_n,
  output logic                       primary_system_error_n,
  output logic                       primary_system_error_oe,
  output logic                       secondary_parity_error_n,
  output logic                       secondary_parity_error_oe,
  output logic                       retry_exhausted,
  output logic                       irq
);

  bper_pkg::bper_state_t q;
  bper_pkg::bper_state_t d;

  logic       wr;
  logic       rd;
  logic       sec_serr_seen;
  logic       ppe_seen;
  logic       pri_resp;
  logic       sec_resp;
  logic [7:0] ev;
  logic [7:0] gated;
  logic       fire;
  logic       sperr_cond;
  logic       serr_en;
  logic       rd_setup;
  logic       wr_ctl;
  logic       wr_dis;
  logic       wr_rsn;
  logic       wr_sts;
  logic       wr_lim;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = q.prdata;

  // pins pass three flops; a level counts once stages two and three agree
  assign sec_serr_seen = !q.ssync[1] && !q.ssync[2];
  assign ppe_seen = !q.psync[1] && !q.psync[2];
  assign pri_resp = q.ctl[bper_pkg::CTL_PRI_PERR_RESP];
  assign sec_resp = q.ctl[bper_pkg::CTL_SEC_PERR_RESP];

  // decoded strobes for the checks at the end of the module
  assign serr_en = q.ctl[bper_pkg::CTL_SERR_EN];
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctl = wr && (paddr == bper_pkg::OFF_CONTROL);
  assign wr_dis = wr && (paddr == bper_pkg::OFF_DISABLE);
  assign wr_rsn = wr && (paddr == bper_pkg::OFF_REASON);
  assign wr_sts = wr && (paddr == bper_pkg::OFF_STATUS);
  assign wr_lim = wr && (paddr == bper_pkg::OFF_RETRY_MAX);

  always_comb
  begin
    // secondary parity error output
    sperr_cond = 1'b0;
    if (sec_phase.active && sec_resp && sec_phase.own_detect &&
        ((sec_phase.is_target && sec_phase.kind != bper_pkg::BPER_READ) ||
         (!sec_phase.is_target && sec_phase.kind == bper_pkg::BPER_READ)))
    begin
      sperr_cond = 1'b1; // R1
    end
    if (pri_phase.active && pri_phase.upstream && !pri_phase.is_target &&
        pri_phase.kind == bper_pkg::BPER_DELAYED && ppe_seen && pri_resp && sec_resp)
    begin
      sperr_cond = 1'b1; // R2
    end

    ev = '0;
    // far-target parity on posted writes only
    ev[bper_pkg::EV_PARITY] =
      pri_resp && sec_resp && // R5
      ((pri_phase.active && pri_phase.upstream && !pri_phase.is_target &&
        pri_phase.kind == bper_pkg::BPER_POSTED && ppe_seen) || // R3 R4 R19
       (sec_phase.active && !sec_phase.upstream && !sec_phase.is_target &&
        sec_phase.kind == bper_pkg::BPER_POSTED && sec_phase.own_detect)); // R3 R4 R19
    ev[bper_pkg::EV_TABORT] = fwd_ev.tabort_pw; // R10
    ev[bper_pkg::EV_MABORT] = fwd_ev.mabort_pw; // R11
    ev[bper_pkg::EV_PW_RETRY] = fwd_ev.retry_pw && retry_exhausted; // R12
    ev[bper_pkg::EV_DW_RETRY] = fwd_ev.retry_dw && retry_exhausted; // R13
    ev[bper_pkg::EV_DR_RETRY] = fwd_ev.retry_dr && retry_exhausted; // R14
    ev[bper_pkg::EV_MTO] = fwd_ev.mto_dt && q.ctl[bper_pkg::CTL_MTO_SERR_EN]; // R15 R18
    ev[bper_pkg::EV_SEC_SERR] = sec_serr_seen && q.ctl[bper_pkg::CTL_SERR_FWD_EN]; // R8

    gated = ev & ~q.disable_m; // R17
    gated[bper_pkg::EV_MTO] = ev[bper_pkg::EV_MTO]; // R18
    fire = q.ctl[bper_pkg::CTL_SERR_EN] && (gated != 8'h00); // R6

    d = q;
    d.ssync = {q.ssync[1:0], secondary_system_error_n};
    d.psync = {q.psync[1:0], primary_parity_error_n};
    d.pserr = fire; // R6
    d.sperr = sperr_cond;

    // register writes; clear bits by writing one, hardware set wins
    if (wr)
    begin
      if (paddr == bper_pkg::OFF_CONTROL)
        d.ctl = pwdata[4:0];
      else if (paddr == bper_pkg::OFF_DISABLE)
        d.disable_m = pwdata[7:0];
      else if (paddr == bper_pkg::OFF_REASON)
        d.reason = q.reason & ~pwdata[7:0];
      else if (paddr == bper_pkg::OFF_STATUS)
        d.status = q.status & ~pwdata[1:0];
      else if (paddr == bper_pkg::OFF_IRQ_STATUS)
        d.irq_st = q.irq_st & ~pwdata[7:0];
      else if (paddr == bper_pkg::OFF_IRQ_MASK)
        d.irq_mask = pwdata[7:0];
      else if (paddr == bper_pkg::OFF_RETRY_MAX)
        d.retry_max = pwdata[24:0];
    end
    if (fire)
    begin
      d.reason = d.reason | gated; // R16
      d.status[bper_pkg::ST_SIGNALED_SERR] = 1'b1; // R7
    end
    if (sec_serr_seen)
      d.status[bper_pkg::ST_RECEIVED_SERR] = 1'b1; // R9
    d.irq_st = d.irq_st | ev;

    // read data; unmapped addresses read zero
    d.prdata = q.prdata;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == bper_pkg::OFF_CONTROL)
        d.prdata = {27'h0, q.ctl};
      else if (paddr == bper_pkg::OFF_DISABLE)
        d.prdata = {24'h0, q.disable_m};
      else if (paddr == bper_pkg::OFF_REASON)
        d.prdata = {24'h0, q.reason};
      else if (paddr == bper_pkg::OFF_STATUS)
        d.prdata = {30'h0, q.status};
      else if (paddr == bper_pkg::OFF_IRQ_STATUS)
        d.prdata = {24'h0, q.irq_st};
      else if (paddr == bper_pkg::OFF_IRQ_MASK)
        d.prdata = {24'h0, q.irq_mask};
      else if (paddr == bper_pkg::OFF_RETRY_MAX)
        d.prdata = {7'h0, q.retry_max};
      else
        d.prdata = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q.ctl       <= bper_pkg::CTL_RESET;
      q.disable_m <= bper_pkg::EV_RESET;
      q.reason    <= bper_pkg::EV_RESET;
      q.status    <= 2'h0;
      q.irq_st    <= bper_pkg::EV_RESET;
      q.irq_mask  <= bper_pkg::EV_RESET;
      q.retry_max <= bper_pkg::RETRY_MAX_RESET;
      q.pserr     <= 1'b0;
      q.sperr     <= 1'b0;
      q.ssync     <= 3'h7;
      q.psync     <= 3'h7;
      q.prdata    <= 32'h0;
    end
    else
    begin
      q <= d;
    end
  end

  assign retry_exhausted = (retry_count >= q.retry_max);
  assign primary_system_error_n = !q.pserr;
  assign primary_system_error_oe = q.pserr;
  assign secondary_parity_error_n = !q.sperr;
  assign secondary_parity_error_oe = q.sperr;
  assign irq = |(q.irq_st & q.irq_mask);

  read_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd |=> $stable(prdata))
    else $error("read data moved after access");

  serr_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    !q.ctl[bper_pkg::CTL_SERR_EN] |=> !primary_system_error_oe)
    else $error("system error without enable");

  signaled_status_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    primary_system_error_oe |-> q.status[bper_pkg::ST_SIGNALED_SERR])
    else $error("system error without signaled status");

  serr_forward_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (sec_serr_seen && q.ctl[bper_pkg::CTL_SERR_FWD_EN] && q.ctl[bper_pkg::CTL_SERR_EN]
     && !q.disable_m[bper_pkg::EV_SEC_SERR]) |=> !primary_system_error_n)
    else $error("secondary system error not forwarded");

  received_serr_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    sec_serr_seen |=> q.status[bper_pkg::ST_RECEIVED_SERR])
    else $error("received status not set");

  parity_resp_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (!pri_resp || !sec_resp) |-> !ev[bper_pkg::EV_PARITY])
    else $error("parity event without both response bits");

  reason_record_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    fire |=> ((q.reason & $past(gated)) == $past(gated)))
    else $error("reason not recorded");

  disable_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    ((ev & ~q.disable_m) == 8'h00 && !ev[bper_pkg::EV_MTO]) |=> !primary_system_error_oe)
    else $error("disabled event raised system error");

  sec_parity_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    secondary_parity_error_oe |-> $past(sec_resp))
    else $error("secondary parity output without response bit");

  serr_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    fire |=> primary_system_error_oe && !primary_system_error_n)
    else $error("system error not driven");

  serr_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    !fire |=> !primary_system_error_oe)
    else $error("system error driven without cause");

  sperr_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // R1 R2
    sperr_cond |=> secondary_parity_error_oe && !secondary_parity_error_n)
    else $error("secondary parity output not driven");

  sperr_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    !sperr_cond |=> !secondary_parity_error_oe)
    else $error("secondary parity output without cause");

  sperr_resp_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    !sec_resp |=> !secondary_parity_error_oe)
    else $error("secondary parity output with response off");

  sperr_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (!pri_resp && !sec_phase.own_detect) |=> !secondary_parity_error_oe)
    else $error("forwarded parity without primary response");

  parity_kind_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
    (pri_phase.kind != bper_pkg::BPER_POSTED && sec_phase.kind != bper_pkg::BPER_POSTED)
    |-> !ev[bper_pkg::EV_PARITY])
    else $error("parity event outside posted write");

  parity_target_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (pri_phase.is_target && sec_phase.is_target) |-> !ev[bper_pkg::EV_PARITY])
    else $error("parity event while target");

  parity_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (!pri_phase.active && !sec_phase.active) |-> !ev[bper_pkg::EV_PARITY])
    else $error("parity event with idle buses");

  parity_up_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (!sec_phase.active && !pri_phase.upstream) |-> !ev[bper_pkg::EV_PARITY])
    else $error("primary parity event not upstream");

  parity_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (!sec_phase.active && !ppe_seen) |-> !ev[bper_pkg::EV_PARITY])
    else $error("primary parity event without pin");

  parity_serr_a: assert property (@(posedge pclk) disable iff (!presetn) // R3 R5
    (ev[bper_pkg::EV_PARITY] && serr_en && !q.disable_m[bper_pkg::EV_PARITY]) |=>
    primary_system_error_oe)
    else $error("parity event not reported");

  tabort_serr_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (fwd_ev.tabort_pw && serr_en && !q.disable_m[bper_pkg::EV_TABORT]) |=>
    primary_system_error_oe)
    else $error("target abort not reported");

  mabort_serr_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (fwd_ev.mabort_pw && serr_en && !q.disable_m[bper_pkg::EV_MABORT]) |=>
    primary_system_error_oe)
    else $error("master abort not reported");

  pw_retry_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (fwd_ev.retry_pw && retry_exhausted && serr_en && !q.disable_m[bper_pkg::EV_PW_RETRY]) |=>
    primary_system_error_oe)
    else $error("posted retry exhaustion not reported");

  dw_retry_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (fwd_ev.retry_dw && retry_exhausted && serr_en && !q.disable_m[bper_pkg::EV_DW_RETRY]) |=>
    primary_system_error_oe)
    else $error("delayed write retry exhaustion not reported");

  dr_retry_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (fwd_ev.retry_dr && retry_exhausted && serr_en && !q.disable_m[bper_pkg::EV_DR_RETRY]) |=>
    primary_system_error_oe)
    else $error("delayed read retry exhaustion not reported");

  retry_short_a: assert property (@(posedge pclk) disable iff (!presetn) // R12 R13 R14
    !retry_exhausted |-> !ev[bper_pkg::EV_PW_RETRY] && !ev[bper_pkg::EV_DW_RETRY]
    && !ev[bper_pkg::EV_DR_RETRY])
    else $error("retry event below the limit");

  mto_serr_a: assert property (@(posedge pclk) disable iff (!presetn) // R15 R18
    (fwd_ev.mto_dt && q.ctl[bper_pkg::CTL_MTO_SERR_EN] && serr_en) |=> primary_system_error_oe)
    else $error("master timeout not reported");

  mto_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
    !q.ctl[bper_pkg::CTL_MTO_SERR_EN] |-> !ev[bper_pkg::EV_MTO])
    else $error("master timeout event with enable off");

  fwd_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !q.ctl[bper_pkg::CTL_SERR_FWD_EN] |-> !ev[bper_pkg::EV_SEC_SERR])
    else $error("forward event with enable off");

  reason_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (!fire && !wr_rsn) |=> $stable(q.reason))
    else $error("reason changed without cause");

  signaled_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    fire |=> q.status[bper_pkg::ST_SIGNALED_SERR])
    else $error("signaled status not set");

  status_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R7 R9
    (!fire && !sec_serr_seen && !wr_sts) |=> $stable(q.status))
    else $error("status changed without cause");

  irq_record_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev != 8'h00) |=> (q.irq_st & $past(ev)) == $past(ev))
    else $error("event not recorded in irq status");

  ctl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl |=> {27'h0, q.ctl} == ($past(pwdata) & 32'h1f))
    else $error("control write lost");

  ctl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctl |=> $stable(q.ctl))
    else $error("control changed without write");

  disable_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    wr_dis |=> {24'h0, q.disable_m} == ($past(pwdata) & 32'hff))
    else $error("disable write lost");

  disable_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    !wr_dis |=> $stable(q.disable_m))
    else $error("disable changed without write");

  limit_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    wr_lim |=> {7'h0, q.retry_max} == ($past(pwdata) & 32'h1ffffff))
    else $error("retry limit write lost");

  prdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_setup |=> $stable(prdata))
    else $error("read data changed outside setup");

endmodule : bper_top

// >>> bper_far.sv
// far-side bus activity model: phases, forwarding events and error pins
module bper_far (
  input  wire logic        pclk,
  output bper_pkg::bper_phase_t  pri_phase,
  output bper_pkg::bper_phase_t  sec_phase,
  output bper_pkg::bper_fwd_ev_t fwd_ev,
  output logic [24:0]      retry_count,
  output logic             pri_perr_n,
  output logic             sec_serr_n
);
  // pins rest at the pull-up level, phases idle between transfers
  initial
  begin
    pri_phase = '0;
    sec_phase = '0;
    fwd_ev = '0;
    retry_count = '0;
    pri_perr_n = 1'b1;
    sec_serr_n = 1'b1;
  end

  task automatic ev(input logic [5:0] e, input logic [24:0] n);
    @(posedge pclk);
    fwd_ev <= e;
    retry_count <= n;
    @(posedge pclk);
    fwd_ev <= '0;
  endtask : ev

  // phase held long enough for the pin to cross the input synchroniser
  task automatic perr(input logic pri, input logic [5:0] ph, input logic pin);
    @(posedge pclk);
    if (pri)
      pri_phase <= ph;
    else
      sec_phase <= ph;
    pri_perr_n <= ~pin;
    repeat (6) @(posedge pclk);
    pri_phase <= '0;
    sec_phase <= '0;
    pri_perr_n <= 1'b1;
  endtask : perr

  task automatic sserr();
    @(posedge pclk);
    sec_serr_n <= 1'b0;
    repeat (2) @(posedge pclk);
    sec_serr_n <= 1'b1;
  endtask : sserr
endmodule : bper_far

// >>> bridge_parity_system_error_report_bench.sv
// self-checking bench of the error report block
module bridge_parity_system_error_report_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pserr_n, pserr_oe, sperr_n, sperr_oe, irq;
  bper_pkg::bper_phase_t pri_phase, sec_phase;
  bper_pkg::bper_fwd_ev_t fwd_ev;
  logic [24:0] retry_count;
  logic pperr_n, sserr_n, p, s, rex;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;

  always #20 pclk = ~pclk;

  bper_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pri_phase, .sec_phase, .fwd_ev, .retry_count,
    .primary_parity_error_n(pperr_n), .secondary_system_error_n(sserr_n),
    .primary_system_error_n(pserr_n), .primary_system_error_oe(pserr_oe),
    .secondary_parity_error_n(sperr_n), .secondary_parity_error_oe(sperr_oe),
    .retry_exhausted(rex), .irq);
  bper_far far (.pclk, .pri_phase, .sec_phase, .fwd_ev, .retry_count,
    .pri_perr_n(pperr_n), .sec_serr_n(sserr_n));

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    chk("slave error", 32'h0, {31'h0, pslverr});
    if (!w)
      chk($sformatf("reg %h", a), d, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, e);
  endtask : rd

  // records whether either error output was driven low in the window
  task automatic watch();
    p = 1'b0;
    s = 1'b0;
    repeat (14)
    begin
      @(negedge pclk);
      if (pserr_n === 1'b0 && pserr_oe === 1'b1)
        p = 1'b1;
      if (sperr_n === 1'b0 && sperr_oe === 1'b1)
        s = 1'b1;
    end
  endtask : watch

  task automatic ev_try(input logic [5:0] e, input logic [24:0] n, input logic [31:0] c,
                        input logic ex);
    wr(bper_pkg::OFF_CONTROL, c);
    fork
      far.ev(e, n);
      watch();
    join
    chk("event serr", {31'h0, ex}, {31'h0, p});
    chk("retry exhausted", {31'h0, n >= 25'h4}, {31'h0, rex});
  endtask : ev_try

  task automatic pt(input logic pri, input logic [5:0] ph, input logic pin,
                    input logic [31:0] c, input logic ep, input logic es);
    wr(bper_pkg::OFF_CONTROL, c);
    fork
      far.perr(pri, ph, pin);
      watch();
    join
    chk("parity serr", {31'h0, ep}, {31'h0, p});
    chk("parity sperr", {31'h0, es}, {31'h0, s});
  endtask : pt

  task automatic t_reset();
    chk("serr idle", 32'h1, {31'h0, pserr_n});
    chk("sperr idle", 32'h1, {31'h0, sperr_n});
    chk("irq idle", 32'h0, {31'h0, irq});
    rd(bper_pkg::OFF_IRQ_STATUS, 32'h0);
    rd(bper_pkg::OFF_IRQ_MASK, 32'h0);
    rd(bper_pkg::OFF_CONTROL, 32'h0);
    rd(bper_pkg::OFF_DISABLE, 32'h0);
    rd(bper_pkg::OFF_REASON, 32'h0);
    rd(bper_pkg::OFF_STATUS, 32'h0);
    rd(bper_pkg::OFF_RETRY_MAX, 32'h1000000);
    rd(8'h40, 32'h0);
  endtask : t_reset

  task automatic t_parity();
    pt(1'b0, 6'h29, 1'b0, 32'h1f, 1'b1, 1'b0);
    pt(1'b1, 6'h2c, 1'b1, 32'h1f, 1'b1, 1'b0);
    pt(1'b0, 6'h2f, 1'b0, 32'h1f, 1'b0, 1'b1);
    pt(1'b0, 6'h29, 1'b0, 32'h1b, 1'b0, 1'b0);
    pt(1'b0, 6'h29, 1'b0, 32'h1e, 1'b0, 1'b0);
    pt(1'b0, 6'h21, 1'b0, 32'h1f, 1'b0, 1'b1);
    pt(1'b0, 6'h21, 1'b0, 32'h1b, 1'b0, 1'b0);
    pt(1'b0, 6'h31, 1'b0, 32'h1f, 1'b0, 1'b0);
    pt(1'b1, 6'h34, 1'b1, 32'h1f, 1'b0, 1'b1);
  endtask : t_parity

  task automatic t_fwd();
    wr(bper_pkg::OFF_STATUS, 32'h3);
    wr(bper_pkg::OFF_REASON, 32'hff);
    wr(bper_pkg::OFF_CONTROL, 32'h1f);
    fork
      far.sserr();
      watch();
    join
    chk("fwd serr", 32'h1, {31'h0, p});
    rd(bper_pkg::OFF_STATUS, 32'h3);
    rd(bper_pkg::OFF_REASON, 32'h80);
    wr(bper_pkg::OFF_STATUS, 32'h3);
    wr(bper_pkg::OFF_CONTROL, 32'h17);
    fork
      far.sserr();
      watch();
    join
    chk("fwd off serr", 32'h0, {31'h0, p});
    rd(bper_pkg::OFF_STATUS, 32'h2);
  endtask : t_fwd

  task automatic t_events();
    logic [5:0] e;
    wr(bper_pkg::OFF_RETRY_MAX, 32'h4);
    for (int i = 0; i < 6; i++)
    begin
      e = 6'h20 >> i;
      wr(bper_pkg::OFF_REASON, 32'hff);
      wr(bper_pkg::OFF_DISABLE, 32'h0);
      ev_try(e, 25'h4, 32'h1f, 1'b1);
      rd(bper_pkg::OFF_REASON, 32'h1 << (i + 1));
      ev_try(e, 25'h4, 32'h1d, 1'b0);
      ev_try(e, 25'h3, 32'h1f, !(i inside {2, 3, 4}));
      ev_try(e, 25'h4, 32'h0f, i != 5);
      wr(bper_pkg::OFF_DISABLE, 32'h1 << (i + 1));
      ev_try(e, 25'h4, 32'h1f, i == 5);
    end
  endtask : t_events

  // masked, unmasked and cleared interrupt
  task automatic t_irq();
    wr(bper_pkg::OFF_IRQ_STATUS, 32'hff);
    wr(bper_pkg::OFF_IRQ_MASK, 32'h0);
    ev_try(6'h20, 25'h4, 32'h1f, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(bper_pkg::OFF_IRQ_STATUS, 32'h2);
    wr(bper_pkg::OFF_IRQ_MASK, 32'h2);
    @(negedge pclk);
    chk("irq up", 32'h1, {31'h0, irq});
    wr(bper_pkg::OFF_IRQ_STATUS, 32'h2);
    @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : t_irq

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_parity();
    t_fwd();
    t_events();
    t_irq();
    wrap_up();
  end
endmodule : bridge_parity_system_error_report_bench
